// ===== inc/gyro_status_pkg.sv
// constants, carriers and checksum helper for the rate sensor status message
// assumes a single 125 MHz system clock domain in the user of this package
package gyro_status_pkg;

  // frame geometry
  localparam int MSG_BITS = 48;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] MSG_BITS_CNT = 6'h30;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3F;

  // status byte field values
  localparam logic [1:0] MSG_TYPE_RATE_TEMP = 2'h0;
  localparam logic [2:0] OP_STATE_NORMAL = 3'h1;

  // temperature word at 0 degC, scale is 2.75 counts per degC
  localparam logic [15:0] TEMP_AT_ZERO_C = 16'h0200;

  // command byte is the first byte shifted in; its bit 6 enables self test
  localparam int CMD_SELF_TEST_POS = 46;

  // reset values
  localparam logic SELF_TEST_RST = 1'b0;
  localparam logic PREV_CMD_BAD_RST = 1'b0;

  typedef struct packed {
    logic fail;
    logic [1:0] msgType;
    logic prevCmdBad;
    logic selfTest;
    logic [2:0] opState;
  } status_s;

  typedef struct packed {
    status_s status;
    logic [15:0] rate;
    logic [15:0] temp;
    logic [7:0] checksum;
  } status_msg_s;

  // low byte of the inverted sum of the five leading bytes
  function automatic logic [7:0] msg_checksum(input logic [39:0] head);
    logic [10:0] sum;
    sum = 11'h000;
    for (int i = 0; i < 5; i++) begin
      sum = sum + {3'h0, head[i*8 +: 8]};
    end
    return ~sum[7:0];
  endfunction

endpackage

// ===== hw/gyro_spi_status_message.sv
// spi mode 0 slave that frames the 48-bit status message and takes the command message
// assumes select, serial clock and data-in come from an external master, async to clk
//
// Rules for the block and its host
// R01: status top bit is one when internal checks have failed, else zero.
// R02: host ignores rate and temperature bytes when the fail flag is one.
// R03: fail flag is also forced to one while commanded self test is enabled.
// R04: status bits six and five carry message type 00, rate and temperature.
// R05: bit four flags a bad-checksum previous command, which is then discarded.
// R06: after a corrupt command the last valid command's selection stays in force.
// R07: status bit three shows whether commanded self test is enabled.
// R08: the three low status bits read 001 for normal operation.
// R09: rate is a signed 16-bit word in bytes two and three, msb first.
// R10: temperature is an unsigned 16-bit word in bytes four and five, msb first.
// R11: temperature reads 0x0200 at 0 degC, scaled 2.75 counts per degree.
// R12: the sixth byte is a checksum over the five preceding bytes.
// R13: host polls near 1 kHz, at most 10 kHz, not below 500 Hz; the host model polls about every 6.75 us.
// R14: host serial clock near 1 MHz, kept between 100 kHz and 8 MHz; the host model clocks at 8 MHz, a 125 ns period.
// R15: checksum is the low byte of the inverted sum of bytes one to five.
// R16: each transfer moves exactly 48 bits each way while select is low.
// R17: slave in mode 0: clock idles low, data sampled on rising edge.
// R18: host enables commanded self test with bit six of the command byte.
// R19: message goes out status byte first, msb of each byte first.
`timescale 1ns/1ps
`default_nettype none

module gyro_spi_status_message (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spiSelN,
  input wire logic spiClk,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic signed [15:0] rateWord,
  input wire logic signed [15:0] tempDelta,
  input wire logic checksFailed,
  output logic selfTestOn,
  output logic prevCmdBad,
  output logic [1:0] msgType,
  output logic cmdTaken
);
  import gyro_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges

  logic [2:0] selSyncQ;
  logic [2:0] sckSyncQ;
  logic [1:0] mosiSyncQ;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selSyncQ <= 3'h7;
      sckSyncQ <= 3'h0;
      mosiSyncQ <= 2'h0;
    end else begin
      selSyncQ <= {selSyncQ[1:0], spiSelN};
      sckSyncQ <= {sckSyncQ[1:0], spiClk};
      mosiSyncQ <= {mosiSyncQ[0], spiMosi};
    end
  end

  // edges of a synchronised pin: stage 2 is now, stage 3 one clock earlier
  function automatic logic rise_of(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  function automatic logic fall_of(input logic [2:0] s);
    return ~s[1] & s[2];
  endfunction

  wire selLow = ~selSyncQ[1];
  wire selFall = fall_of(selSyncQ);
  wire selRise = rise_of(selSyncQ);
  // mode 0: capture on rising, launch on falling
  wire sckRise = selLow & rise_of(sckSyncQ); // R17
  wire sckFall = selLow & fall_of(sckSyncQ); // R17
  wire mosiBit = mosiSyncQ[1];

  ////////////////////////////////////////////////////////////////////////////
  // outgoing message, built from the state at the select falling edge

  logic selfTestQ;
  logic prevCmdBadQ;
  logic [1:0] msgTypeQ;
  status_s statusNow;
  status_msg_s msgNow;
  wire [15:0] tempNow = 16'(TEMP_AT_ZERO_C + 16'(tempDelta)); // R11

  assign statusNow.fail = checksFailed | selfTestQ; // R01 R03
  assign statusNow.msgType = msgTypeQ; // R04
  assign statusNow.prevCmdBad = prevCmdBadQ; // R05
  assign statusNow.selfTest = selfTestQ; // R07
  assign statusNow.opState = OP_STATE_NORMAL; // R08
  assign msgNow.status = statusNow;
  assign msgNow.rate = rateWord; // R09
  assign msgNow.temp = tempNow; // R10
  // head built from the fields, so the checksum has no path through msgNow itself
  wire [39:0] msgHead = {statusNow, rateWord, tempNow};
  assign msgNow.checksum = msg_checksum(msgHead); // R12 R15

  ////////////////////////////////////////////////////////////////////////////
  // shift paths; transmit leaves msb first with the status byte leading

  logic [MSG_BITS-1:0] txQ;
  logic [MSG_BITS-1:0] txD;
  logic [MSG_BITS-1:0] rxQ;
  logic [MSG_BITS-1:0] rxD;
  logic [CNT_W-1:0] bitCntQ;
  logic [CNT_W-1:0] bitCntD;
  logic misoQ;
  logic misoD;
  logic oeQ;

  assign txD = selFall ? MSG_BITS'(msgNow) : (sckFall ? {txQ[MSG_BITS-2:0], 1'b0} : txQ); // R19
  assign misoD = selFall ? msgNow.status.fail : (sckFall ? txQ[MSG_BITS-2] : misoQ); // R19 R17
  assign rxD = sckRise ? {rxQ[MSG_BITS-2:0], mosiBit} : rxQ; // R17
  // saturate so an overlong frame cannot wrap back to a legal count
  assign bitCntD = selFall ? '0
                 : (sckRise && bitCntQ != CNT_SAT) ? bitCntQ + 6'h01 : bitCntQ;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txQ <= '0;
      rxQ <= '0;
      bitCntQ <= '0;
      misoQ <= 1'b0;
      oeQ <= 1'b0;
    end else begin
      txQ <= txD;
      rxQ <= rxD;
      bitCntQ <= bitCntD;
      misoQ <= misoD;
      oeQ <= selLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command check at end of frame; a short or long frame counts as corrupt

  wire lengthOk = bitCntQ == MSG_BITS_CNT; // R16
  wire sumOk = msg_checksum(rxQ[47:8]) == rxQ[7:0]; // R15
  wire cmdGood = selRise & lengthOk & sumOk;
  wire cmdBad = selRise & ~(lengthOk & sumOk);

  // only one message type exists, so a good command re-selects rate and temperature
  assign msgType = msgTypeQ;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selfTestQ <= SELF_TEST_RST;
      prevCmdBadQ <= PREV_CMD_BAD_RST;
      msgTypeQ <= MSG_TYPE_RATE_TEMP;
      cmdTaken <= 1'b0;
    end else begin
      cmdTaken <= cmdGood;
      if (cmdGood) begin
        selfTestQ <= rxQ[CMD_SELF_TEST_POS]; // R18 R07
        msgTypeQ <= MSG_TYPE_RATE_TEMP; // R04
        prevCmdBadQ <= 1'b0; // R05
      end else if (cmdBad) begin
        prevCmdBadQ <= 1'b1; // R05 R06
      end
    end
  end

  assign spiMiso = misoQ;
  assign spiMisoOe = oeQ;
  assign selfTestOn = selfTestQ;
  assign prevCmdBad = prevCmdBadQ;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fail_on_check: assert property (selFall && checksFailed |=> txQ[47]) // R01
    else $error("fail flag not set after failed checks");
  a_ok_when_clean: assert property (selFall && !checksFailed && !selfTestQ |=> !txQ[47]) // R01
    else $error("fail flag set while checks pass");
  a_fail_selftest: assert property (selFall && selfTestQ |=> txQ[47] && txQ[43]) // R03
    else $error("self test did not force fail flag");
  a_type_code: assert property (selFall |=> txQ[46:45] == MSG_TYPE_RATE_TEMP) // R04
    else $error("message type code not 00");
  a_bad_cmd_flag: assert property (cmdBad |=> prevCmdBadQ && !cmdTaken) // R05
    else $error("corrupt command not flagged");
  a_good_cmd_clear: assert property (cmdGood |=> !prevCmdBadQ && cmdTaken) // R05
    else $error("valid command did not clear flag");
  a_hold_on_bad: assert property (cmdBad |=> $stable(selfTestQ) && $stable(msgTypeQ)) // R06
    else $error("corrupt command changed selection");
  a_st_bit: assert property (selFall |=> txQ[44] == $past(prevCmdBadQ) && txQ[43] == $past(selfTestQ)) // R07
    else $error("status bits 4 or 3 wrong");
  a_low_bits: assert property (selFall |=> txQ[42:40] == OP_STATE_NORMAL) // R08
    else $error("state code not 001");
  a_rate_place: assert property (selFall |=> txQ[39:24] == $past(rateWord)) // R09
    else $error("rate word misplaced");
  a_temp_place: assert property (selFall |=> txQ[23:8] == 16'($past(tempDelta) + TEMP_AT_ZERO_C)) // R10 R11
    else $error("temperature word wrong");
  a_csum_byte: assert property (selFall |=> txQ[7:0] == msg_checksum(txQ[47:8])) // R12 R15
    else $error("checksum byte wrong");
  a_short_frame: assert property (selRise && bitCntQ != MSG_BITS_CNT |=> prevCmdBadQ && !cmdTaken) // R16
    else $error("frame of wrong length accepted");
  a_launch_fall: assert property (sckFall |=> spiMiso == $past(txQ[46]) && txQ[47] == spiMiso) // R17 R19
    else $error("data not launched on falling edge");

  c_good_cmd: cover property (cmdGood);
  c_bad_cmd: cover property (cmdBad);
  c_self_test_on: cover property (cmdGood ##1 selfTestQ);
  c_full_frame: cover property (selRise && bitCntQ == MSG_BITS_CNT);
  c_fail_sent: cover property (selFall && checksFailed);

  ////////////////////////////////////////////////////////////////////////////
  // framing and shift checks

  // helper: clocks since the last select rise, saturating at 15
  logic [3:0] gapCntQ;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gapCntQ <= 4'hF;
    end else if (selRise) begin
      gapCntQ <= 4'h0;
    end else if (gapCntQ != 4'hF) begin
      gapCntQ <= gapCntQ + 4'h1;
    end
  end

  // select pin edge reaches the detector after the two sync stages
  a_sel_detect: assert property ($fell(selSyncQ[0]) |=> selFall) // R16
    else $error("select fall not detected");

  // every frame starts counting from zero
  a_load_count: assert property (selFall |=> bitCntQ == '0) // R16
    else $error("bit count not cleared at frame start");

  a_count_step: assert property (sckRise && !selFall && bitCntQ != CNT_SAT |=> bitCntQ == $past(bitCntQ) + 6'h01) // R16
    else $error("bit count did not step");

  // saturation keeps an overlong frame illegal
  a_count_sat: assert property (bitCntQ == CNT_SAT && !selFall |=> bitCntQ == CNT_SAT) // R16
    else $error("bit count left saturation");

  // clock edges while deselected are ignored
  a_idle_count: assert property (!selLow |=> $stable(bitCntQ)) // R16
    else $error("bit count moved while deselected");

  a_idle_tx: assert property (!selLow |=> $stable(txQ)) // R16
    else $error("transmit shifter moved while deselected");

  // released line keeps its level, the enable is what frees the bus
  a_idle_miso: assert property (!selLow |=> $stable(spiMiso)) // R16
    else $error("data out moved while deselected");

  a_oe_follow: assert property (1'b1 |=> spiMisoOe == $past(selLow)) // R16
    else $error("output enable does not follow select");

  // limitation: assumes frames longer than 15 clocks
  a_oe_gap: assert property (gapCntQ != 4'hF && !selLow |-> !spiMisoOe) // R16
    else $error("output enabled between frames");

  // status msb must be on the line before the first rising clock
  a_miso_first: assert property (selFall |=> spiMiso == txQ[47] && spiMisoOe) // R19
    else $error("first bit not presented at frame start");

  a_tx_stand: assert property (selLow && !selFall && !sckFall |=> $stable(txQ)) // R19
    else $error("transmit shifter moved without a falling clock");

  a_fill_zero: assert property (sckFall && !selFall |=> !txQ[0]) // R19
    else $error("shifter not filled with zero");

  // each bit stands until the next falling clock
  a_miso_stand: assert property (selLow && !selFall && !sckFall |=> $stable(spiMiso)) // R17
    else $error("data out changed between falling clocks");

  a_rx_capture: assert property (sckRise |=> rxQ[0] == $past(mosiBit)) // R17
    else $error("command bit not captured on rising clock");

  a_rx_hold: assert property (!sckRise |=> $stable(rxQ)) // R17
    else $error("receive shifter moved without a rising clock");

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance checks

  // state only moves at a frame end
  a_cmd_only_end: assert property (!selRise |=> $stable(selfTestQ) && $stable(prevCmdBadQ)) // R06
    else $error("command state moved outside frame end");

  a_st_from_cmd: assert property (cmdGood |=> selfTestQ == $past(rxQ[CMD_SELF_TEST_POS])) // R07
    else $error("self test not taken from command");

  // a full frame with a wrong checksum is still refused
  a_bad_sum: assert property (selRise && lengthOk && !sumOk |=> prevCmdBadQ) // R15
    else $error("bad command checksum accepted");

  a_taken_pulse: assert property (cmdTaken |=> !cmdTaken) // R05
    else $error("command taken pulse longer than one clock");

endmodule // gyro_spi_status_message

`default_nettype wire

// ===== test/spi_host_model.sv
// spi mode 0 master standing in for the host microcontroller
// assumes the bench calls xfer; link clock period 125 ns, idle low between frames
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output logic spiSelN,
  output logic spiClk,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  initial begin
    spiSelN = 1'b1;
    spiClk = 1'b0;
    spiMosi = 1'b0;
  end

  // nBits below 48 makes a short, corrupt frame on purpose
  task automatic xfer(input logic [47:0] tx, input int nBits, output logic [47:0] rx);
    rx = 48'h0;
    spiSelN = 1'b0;
    #125;
    for (int i = 47; i > 47 - nBits; i--) begin
      spiMosi = tx[i];
      #62.5 spiClk = 1'b1;
      rx[i] = spiMiso;
      #62.5 spiClk = 1'b0;
    end
    #125 spiSelN = 1'b1;
    // released data line must not keep its last level
    spiMosi = ~spiMosi;
    // gap far below a real poll period so the run stays short; block needs 4 clk
    #500;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ===== test/gyro_spi_status_message_bench.sv
// self-checking bench for the status message slave
// assumes the host model drives the link and the bench drives sensor inputs
`timescale 1ns/1ps
`default_nettype none

module gyro_spi_status_message_bench;
  import gyro_status_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [15:0] rate; logic [15:0] tdel; logic fail;} row_s;
  logic clk, sys_rst, spiSelN, spiClk, spiMosi, spiMiso, spiMisoOe, checksFailed;
  logic selfTestOn, prevCmdBad, cmdTaken, st, pb;
  logic signed [15:0] rateWord, tempDelta;
  logic [1:0] msgType;
  logic [47:0] rx;
  int errors = 0, nChecks = 0, nTaken = 0;
  row_s rows [4] = '{'{8'h00, 16'h12C0, 16'hFF92, 1'b0}, '{8'h40, 16'hF4C0, 16'h00E9, 1'b0},
    '{8'h00, 16'h7FFF, 16'h0000, 1'b1}, '{8'h00, 16'h8000, 16'h0000, 1'b0}};

  gyro_spi_status_message i_gyro_spi_status_message (.clk(clk), .sys_rst(sys_rst), .spiSelN(spiSelN),
    .spiClk(spiClk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .rateWord(rateWord),
    .tempDelta(tempDelta), .checksFailed(checksFailed), .selfTestOn(selfTestOn),
    .prevCmdBad(prevCmdBad), .msgType(msgType), .cmdTaken(cmdTaken));
  spi_host_model i_spi_host_model (.spiSelN(spiSelN), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (cmdTaken === 1'b1) nTaken++;

  function automatic logic [7:0] csum(input logic [39:0] h);
    return ~(h[39:32] + h[31:24] + h[23:16] + h[15:8] + h[7:0]);
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input int nBits, input logic bad, input row_s r);
    logic [39:0] head;
    logic [7:0] stat;
    logic [15:0] tw;
    int k;
    head = {cmd, 32'h0};
    stat = {r.fail | st, MSG_TYPE_RATE_TEMP, pb, st, OP_STATE_NORMAL};
    tw = TEMP_AT_ZERO_C + r.tdel;
    @(negedge clk);
    rateWord = r.rate;
    tempDelta = r.tdel;
    checksFailed = r.fail;
    i_spi_host_model.xfer({head, csum(head) ^ {7'h0, bad}}, nBits, rx);
    k = 0;
    while (spiMisoOe === 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) begin
      errors++;
      results();
    end
    if (nBits == 48) check("message", {stat, r.rate, tw, csum({stat, r.rate, tw})}, rx);
    if (nBits == 48) check("fail", {47'h0, r.fail | st}, {47'h0, rx[47]});
    bad = bad || nBits != 48;
    if (!bad) st = cmd[6];
    pb = bad;
    check("flags", {44'h0, pb, st, MSG_TYPE_RATE_TEMP}, {44'h0, prevCmdBad, selfTestOn, msgType});
  endtask

  initial begin
    {sys_rst, st, pb, checksFailed, rateWord, tempDelta} = {1'b1, 35'h0};
    repeat (20) @(negedge clk);
    check("reset", 48'h0, {42'h0, spiMisoOe, spiMiso, selfTestOn, prevCmdBad, msgType});
    sys_rst = 1'b0;
    foreach (rows[i]) frame(rows[i].cmd, 48, 1'b0, rows[i]);
    frame(8'h40, 48, 1'b0, rows[0]);
    frame(8'h00, 48, 1'b1, rows[1]);
    frame(8'h00, 47, 1'b0, rows[2]);
    frame(8'h00, 48, 1'b0, rows[3]);
    frame(8'h40, 48, 1'b0, rows[0]);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    check("midrst", 48'h0, {44'h0, selfTestOn, prevCmdBad, spiMisoOe, cmdTaken});
    sys_rst = 1'b0;
    check("taken", 48'd7, 48'(nTaken));
    results();
  end
endmodule // gyro_spi_status_message_bench
`default_nettype wire
